//--- hw/cdb_buffers.sv
// Six dual-role CAN message buffers with their register port and send path.
//
// What this block does
// - Select bits 7..2 set each buffer's direction.
// - Select bits 1..0 always read zero.
// - Buffer field registers absent in legacy mode.
// - Select register absent in legacy mode.
// - Transmit extended identifier high byte is read-write.
// - Receive extended identifier low byte is read-only.
// - Transmit extended identifier low byte is writable.
// - Receive data bytes read-only, loaded by controller.
// - Transmit data bytes writable, sent by controller.
// - Receive length code loaded, read-only.
// - Transmit length code written and sent.
// - Receive bit 6 flags remote request frames.
// - Receive length bits 7, 5, 4 read zero.
// - Transmit bit 6 sets the sent remote bit.
// - Transmit length bits 7, 5, 4 read zero.
// - Extended enable chooses the sent frame format.
// - Pending buffer takes only a request bit write; sending buffer is read-only.
// - Full receive buffer takes no new frame.
`timescale 1ns/1ps
module cdb_buffers #(
  parameter int NUM_BUF = cdb_pkg::NUM_BUF,
  parameter int FIFO_DEPTH = cdb_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Controller operating mode, from logic on this clock.
  input wire logic [1:0] opMode,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Received frame from the controller.
  input wire logic rxLoad,
  input wire logic [2:0] rxBuf,
  input wire logic [15:0] rxExtId,
  input wire logic rxRemote,
  input wire logic [3:0] rxLength,
  input wire logic [63:0] rxData,
  // Frame handed to the controller.
  output logic txFrameValid,
  output logic [2:0] txBuf,
  output logic [15:0] txExtId,
  output logic txExtended,
  output logic txRemote,
  output logic [3:0] txLength,
  input wire logic txDone,
  // Data bytes of the frame handed to the controller.
  output logic txByteValid,
  output logic [7:0] txByteData,
  input wire logic txByteReady
);
  if (NUM_BUF < 1 || NUM_BUF > cdb_pkg::NUM_BUF) begin : g_bad_num_buf
    $error("NUM_BUF out of range");
  end

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_STREAM = 3'b010,
    TX_WAIT = 3'b100
  } cdb_tx_t;

  // Page 1..NUM_BUF of the address space maps to buffer 0..NUM_BUF-1.
  function automatic logic pageHit(input logic [7:0] addr);
    logic [3:0] page;
    page = addr[7:4];
    return page >= cdb_pkg::BUF_FIRST_PAGE
      && page < cdb_pkg::BUF_FIRST_PAGE + 4'(NUM_BUF);
  endfunction

  function automatic logic [2:0] pageBuf(input logic [7:0] addr);
    logic [3:0] idx;
    idx = addr[7:4] - cdb_pkg::BUF_FIRST_PAGE;
    return idx[2:0];
  endfunction

  // Reserved codes above eight still carry eight bytes on the wire.
  function automatic logic [3:0] sendCount(input logic [3:0] code, input logic rtr);
    logic [3:0] n;
    n = (code > cdb_pkg::LEN_MAX) ? cdb_pkg::LEN_MAX : code;
    return rtr ? 4'h0 : n;
  endfunction

  logic [NUM_BUF-1:0] txDir;
  logic [7:0] extHi [NUM_BUF];
  logic [7:0] extLo [NUM_BUF];
  logic [3:0] lenCode [NUM_BUF];
  logic [NUM_BUF-1:0] rtrFlag;
  logic [NUM_BUF-1:0] extEn;
  logic [NUM_BUF-1:0] sendReq;
  logic [NUM_BUF-1:0] rxFull;
  logic [7:0] dataMem [NUM_BUF*8];
  cdb_tx_t txState;
  logic [2:0] curBuf;
  logic sndStart;
  logic sndDone;
  logic fifoInValid;
  logic [7:0] fifoInData;
  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  logic fifoOutReady;

  logic present;
  logic hit;
  logic [2:0] wBuf;
  logic [3:0] off;
  logic busyThis;
  logic bufTx;
  logic fieldWr;
  logic ctrlWr;
  logic rxAccept;
  logic [2:0] pick;
  logic pickValid;
  logic [63:0] curData;
  logic abortPick;

  assign present = (opMode != cdb_pkg::MODE_LEGACY);
  assign hit = present && pageHit(regAddr);
  assign wBuf = pageBuf(regAddr);
  assign off = regAddr[3:0];
  assign bufTx = txDir[wBuf];
  assign busyThis = (txState != TX_IDLE) && (curBuf == wBuf);
  // Field writes only land in an idle transmit buffer.
  assign fieldWr = regWr && hit && bufTx && !sendReq[wBuf] && !busyThis;
  assign ctrlWr = regWr && hit && (off == cdb_pkg::OFF_CTRL);
  assign rxAccept = rxLoad && present && (rxBuf < 3'(NUM_BUF))
    && !txDir[rxBuf] && !rxFull[rxBuf];
  // A request withdrawn at the edge that would pick it must not start a frame.
  assign abortPick = ctrlWr && bufTx && wBuf == pick
    && !regWrData[cdb_pkg::CTRL_REQ_BIT];

  always_comb begin
    pick = 3'h0;
    pickValid = 1'b0;
    for (int i = NUM_BUF - 1; i >= 0; i--) begin
      if (sendReq[i] && txDir[i]) begin
        pick = 3'(i);
        pickValid = 1'b1;
      end
    end
  end

  always_comb begin
    curData = 64'h0;
    for (int m = 0; m < 8; m++) begin
      curData[8*m +: 8] = dataMem[{curBuf, 3'(m)}];
    end
  end

  // Direction select.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txDir <= cdb_pkg::SEL_RESET[NUM_BUF-1:0];
    end else if (regWr && present && regAddr == cdb_pkg::SEL_ADDR) begin
      txDir <= regWrData[cdb_pkg::SEL_DIR_LSB +: NUM_BUF];
    end
  end

  // Identifier and length fields.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_BUF; i++) begin
        extHi[i] <= 8'h00;
        extLo[i] <= 8'h00;
        lenCode[i] <= 4'h0;
      end
      rtrFlag <= '0;
      extEn <= '0;
    end else begin
      // A load only reaches a receive buffer and a field write only a transmit
      // buffer, so both may land in one cycle without touching the same entry.
      if (rxAccept) begin
        extHi[rxBuf] <= rxExtId[15:8];
        extLo[rxBuf] <= rxExtId[7:0];
        lenCode[rxBuf] <= rxLength;
        rtrFlag[rxBuf] <= rxRemote;
      end
      if (fieldWr) begin
        case (off)
          cdb_pkg::OFF_EXT_HI: extHi[wBuf] <= regWrData;
          cdb_pkg::OFF_EXT_LO: extLo[wBuf] <= regWrData;
          cdb_pkg::OFF_LEN: begin
            lenCode[wBuf] <= regWrData[3:0];
            rtrFlag[wBuf] <= regWrData[cdb_pkg::LEN_RTR_BIT];
          end
          cdb_pkg::OFF_CTRL: extEn[wBuf] <= regWrData[cdb_pkg::CTRL_EXT_BIT];
          default: ;
        endcase
      end
    end
  end

  // Data field bytes.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int k = 0; k < NUM_BUF * 8; k++) begin
        dataMem[k] <= 8'h00;
      end
    end else begin
      if (rxAccept) begin
        for (int m = 0; m < 8; m++) begin
          dataMem[{rxBuf, 3'(m)}] <= rxData[8*m +: 8];
        end
      end
      if (fieldWr && off[cdb_pkg::OFF_DATA_BIT]) begin
        dataMem[{wBuf, off[2:0]}] <= regWrData;
      end
    end
  end

  // Receive full flags: a frame landing beside a clear keeps its flag set.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxFull <= '0;
    end else begin
      for (int i = 0; i < NUM_BUF; i++) begin
        if (rxAccept && rxBuf == 3'(i)) begin
          rxFull[i] <= 1'b1;
        end else if (ctrlWr && !bufTx && wBuf == 3'(i)
                     && !regWrData[cdb_pkg::CTRL_FULL_BIT]) begin
          rxFull[i] <= 1'b0;
        end
      end
    end
  end

  // Send requests: software may withdraw one only before sending starts.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sendReq <= '0;
    end else begin
      for (int i = 0; i < NUM_BUF; i++) begin
        if (txState == TX_WAIT && txDone && curBuf == 3'(i)) begin
          sendReq[i] <= 1'b0;
        end else if (ctrlWr && bufTx && !busyThis && wBuf == 3'(i)) begin
          sendReq[i] <= regWrData[cdb_pkg::CTRL_REQ_BIT];
        end
      end
    end
  end

  // Send sequencing: lowest pending buffer first.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txState <= TX_IDLE;
      curBuf <= 3'h0;
      sndStart <= 1'b0;
      txFrameValid <= 1'b0;
      txBuf <= 3'h0;
      txExtId <= 16'h0000;
      txExtended <= 1'b0;
      txRemote <= 1'b0;
      txLength <= 4'h0;
    end else begin
      sndStart <= 1'b0;
      case (txState)
        TX_IDLE: begin
          if (present && pickValid && !abortPick) begin
            curBuf <= pick;
            sndStart <= 1'b1;
            txState <= TX_STREAM;
          end
        end
        TX_STREAM: begin
          if (sndDone) begin
            txFrameValid <= 1'b1;
            txBuf <= curBuf;
            txExtId <= {extHi[curBuf], extLo[curBuf]};
            txExtended <= extEn[curBuf];
            txRemote <= rtrFlag[curBuf];
            txLength <= lenCode[curBuf];
            txState <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (txDone) begin
            txFrameValid <= 1'b0;
            txState <= TX_IDLE;
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  cdb_frame_sender u_sender (
    .clk(clk),
    .rstn(rstn),
    .start(sndStart),
    .byteCount(sendCount(lenCode[curBuf], rtrFlag[curBuf])),
    .frameData(curData),
    .done(sndDone),
    .pushValid(fifoInValid),
    .pushData(fifoInData),
    .pushReady(fifoInReady)
  );

  cdb_fifo #(
    .WIDTH(cdb_pkg::FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .inValid(fifoInValid),
    .inData(fifoInData),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(fifoOutReady)
  );

  // Output stage: the byte port comes straight from flip-flops and never shows
  // an unwritten FIFO entry.
  assign fifoOutReady = !txByteValid || txByteReady;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txByteValid <= 1'b0;
      txByteData <= 8'h00;
    end else if (fifoOutReady) begin
      txByteValid <= fifoOutValid;
      if (fifoOutValid) begin
        txByteData <= fifoOutData;
      end
    end
  end

  // Register reads: data stands for one cycle after the strobe.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= 8'h00;
    end else if (!regRd) begin
      regRdData <= 8'h00;
    end else if (present && regAddr == cdb_pkg::SEL_ADDR) begin
      regRdData <= 8'({txDir, 2'b00});
    end else if (hit) begin
      if (off[cdb_pkg::OFF_DATA_BIT]) begin
        regRdData <= dataMem[{wBuf, off[2:0]}];
      end else begin
        case (off)
          cdb_pkg::OFF_EXT_HI: regRdData <= extHi[wBuf];
          cdb_pkg::OFF_EXT_LO: regRdData <= extLo[wBuf];
          cdb_pkg::OFF_LEN: begin
            regRdData <= {1'b0, rtrFlag[wBuf], 2'b00, lenCode[wBuf]};
          end
          cdb_pkg::OFF_CTRL: regRdData <= {5'h00, rxFull[wBuf], extEn[wBuf], sendReq[wBuf]};
          default: regRdData <= 8'h00;
        endcase
      end
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule // cdb_buffers

//--- hw/cdb_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module cdb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Fill side.
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side.
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  logic doPush;
  logic doPop;
  assign inReady = (count != (PW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) wrPtr <= wrPtr + 1'b1;
      if (doPop) rdPtr <= rdPtr + 1'b1;
      count <= count + (PW+1)'(doPush) - (PW+1)'(doPop);
    end
  end
  always_ff @(posedge clk) begin
    if (doPush) mem[wrPtr] <= inData;
  end
endmodule // cdb_fifo

//--- hw/cdb_frame_sender.sv
// Streams the data bytes of one outgoing frame, byte 0 first.
`timescale 1ns/1ps
module cdb_frame_sender (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Frame to stream.
  input wire logic start,
  input wire logic [3:0] byteCount,
  input wire logic [63:0] frameData,
  output logic done,
  // Byte push toward the FIFO.
  output logic pushValid,
  output logic [7:0] pushData,
  input wire logic pushReady
);
  typedef enum logic [1:0] {
    SND_IDLE = 2'b01,
    SND_PUSH = 2'b10
  } cdb_snd_t;
  cdb_snd_t state;
  logic [3:0] index;
  logic [3:0] total;
  logic [63:0] bytes;
  assign pushValid = (state == SND_PUSH) && (index != total);
  assign pushData = bytes[8*index[2:0] +: 8];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= SND_IDLE;
      index <= 4'h0;
      total <= 4'h0;
      bytes <= 64'h0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        SND_IDLE: begin
          if (start) begin
            bytes <= frameData;
            total <= byteCount;
            index <= 4'h0;
            state <= SND_PUSH;
          end
        end
        SND_PUSH: begin
          if (index == total) begin
            done <= 1'b1;
            state <= SND_IDLE;
          end else if (pushReady) begin
            index <= index + 4'h1;
          end
        end
        default: state <= SND_IDLE;
      endcase
    end
  end
endmodule // cdb_frame_sender

//--- hw/cdb_pkg.sv
// Shared constants for the dual-role CAN buffer field block.
package cdb_pkg;
  localparam int NUM_BUF = 6;
  localparam int DATA_BYTES = 8;
  localparam int ADDR_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 8;
  // Register map.
  localparam logic [7:0] SEL_ADDR = 8'h00;
  localparam logic [3:0] BUF_FIRST_PAGE = 4'h1;
  localparam logic [3:0] OFF_EXT_HI = 4'h0;
  localparam logic [3:0] OFF_EXT_LO = 4'h1;
  localparam logic [3:0] OFF_LEN = 4'h2;
  localparam logic [3:0] OFF_CTRL = 4'h3;
  localparam int OFF_DATA_BIT = 3;
  // Field positions.
  localparam int SEL_DIR_LSB = 2;
  localparam int LEN_RTR_BIT = 6;
  localparam int CTRL_REQ_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int CTRL_FULL_BIT = 2;
  // Reset values and codes.
  localparam logic [5:0] SEL_RESET = 6'h00;
  localparam logic [1:0] MODE_LEGACY = 2'h0;
  localparam logic [3:0] LEN_MAX = 4'h8;
endpackage

//--- test/cdb_buffers_properties.sv
// Port-level checks for the dual-role message buffer block.
`timescale 1ns/1ps
module cdb_buffers_properties #(
  parameter int NUM_BUF = 6,
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register port.
  input wire logic [1:0] opMode,
  input wire logic [7:0] regAddr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // Send path.
  input wire logic txFrameValid,
  input wire logic [2:0] txBuf,
  input wire logic [15:0] txExtId,
  input wire logic txRemote,
  input wire logic [3:0] txLength,
  input wire logic txDone,
  input wire logic txByteValid,
  input wire logic [7:0] txByteData,
  input wire logic txByteReady
);
  logic [3:0] nb;
  logic [3:0] sentBytes;
  logic [23:0] frameDesc;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Bytes taken since the last frame ended; valid only if the far side drains first.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) nb <= 4'h0;
    else nb <= txDone ? 4'h0 : nb + 4'(txByteValid && txByteReady);
  end
  // Bytes a frame must carry: none for a remote request, reserved codes carry eight.
  assign sentBytes = txRemote ? 4'h0 : (txLength > 4'h8 ? 4'h8 : txLength);
  assign frameDesc = {txBuf, txExtId, txRemote, txLength};
  sequence byteStall;
    txByteValid && !txByteReady;
  endsequence
  sequence selRd;
    regRd && regAddr == 8'h00 && opMode != 2'h0;
  endsequence
  sequence lenRd;
    regRd && opMode != 2'h0 && regAddr[3:0] == 4'h2 && regAddr[7:4] != 4'h0
      && int'(regAddr[7:4]) <= NUM_BUF;
  endsequence
  sequence frameOn;
    txFrameValid && !txDone;
  endsequence
  sel_pad_zero_a: assert property (selRd |=> regRdData[1:0] == 2'b00)
    else $error("select low bits set");
  legacy_hidden_a: assert property (regRd && opMode == 2'h0 |=> regRdData == 8'h00)
    else $error("register seen in legacy mode");
  len_pad_zero_a: assert property (lenRd |=> (regRdData & 8'hb0) == 8'h00)
    else $error("length pad bits set");
  frame_hold_a: assert property (frameOn |=> txFrameValid && $stable(frameDesc))
    else $error("frame changed while sending");
  frame_end_a: assert property (txDone |-> txFrameValid ##1 !txFrameValid)
    else $error("frame not closed after done");
  byte_hold_a: assert property (byteStall |=> txByteValid && $stable(txByteData))
    else $error("byte dropped while stalled");
  buf_range_a: assert property (txFrameValid |-> int'(txBuf) < NUM_BUF)
    else $error("buffer index out of range");
  count_match_a: assert property (txDone && !txByteValid |-> nb == sentBytes)
    else $error("byte count wrong");
endmodule // cdb_buffers_properties
bind cdb_buffers cdb_buffers_properties #(.NUM_BUF(NUM_BUF), .FIFO_DEPTH(FIFO_DEPTH)) props (
  .clk, .rstn, .opMode, .regAddr, .regRd, .regRdData, .txFrameValid, .txBuf, .txExtId,
  .txRemote, .txLength, .txDone, .txByteValid, .txByteData, .txByteReady);

//--- test/cdb_buffers_test.sv
// Self-checking bench for the dual-role message buffer block.
`timescale 1ns/1ps
module cdb_buffers_test;
  logic clk, rstn, regWr, regRd, txFrameValid, txExtended, txRemote, txDone;
  logic txByteValid, txByteReady, rxLoad, rxRemote;
  logic [1:0] opMode;
  logic [2:0] rxBuf, txBuf;
  logic [3:0] rxLength, txLength;
  logic [7:0] regAddr, regWrData, regRdData, txByteData;
  logic [15:0] rxExtId, txExtId;
  logic [63:0] rxData;
  int fails, n_checks, cyc;
  cdb_buffers dut (.clk, .rstn, .opMode, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .rxLoad, .rxBuf, .rxExtId, .rxRemote, .rxLength, .rxData, .txFrameValid, .txBuf,
    .txExtId, .txExtended, .txRemote, .txLength, .txDone, .txByteValid, .txByteData,
    .txByteReady);
  cdb_ctrl_model m (.clk, .rstn, .txFrameValid, .txByteValid, .txByteData, .txByteReady,
    .txDesc({txBuf, txExtId, txExtended, txRemote, txLength}), .txDone, .rxLoad, .rxBuf,
    .rxExtId, .rxRemote, .rxLength, .rxData);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    {regWr, regAddr, regWrData} <= {1'b1, ad, d};
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk);
    {regRd, regAddr} <= {1'b1, ad};
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk($sformatf("reg %h", ad), {24'h0, e}, {24'h0, regRdData});
  endtask
  function automatic logic [7:0] a(input int n, input int o);
    return {4'(n + 1), 4'(o)};
  endfunction
  // The id write after the request must be refused while the frame is pending.
  task automatic snd(input int b, input logic [7:0] c, input logic [24:0] e, input int nb);
    int k;
    k = m.nf;
    m.got.delete();
    wr(a(b, 3), c);
    wr(a(b, 0), 8'h00);
    for (int i = 0; i < 300 && m.nf == k; i++) @(posedge clk);
    chk("frame", {7'h0, e}, {7'h0, m.desc});
    chk("count", nb, m.got.size());
    foreach (m.got[i]) chk("byte", 8'h10 + i, m.got[i]);
    rd(a(b, 0), 8'ha5);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    {rstn, regWr, regRd, regAddr, regWrData} = '0;
    opMode = 2'h1;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h00, 8'h00);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'hfc);
    wr(8'h00, 8'hf8);
    rd(8'h70, 8'h00);
    wr(a(1, 0), 8'ha5);
    rd(a(1, 0), 8'ha5);
    @(posedge clk);
    opMode <= 2'h0;
    rd(8'h00, 8'h00);
    rd(a(1, 0), 8'h00);
    wr(8'h00, 8'h00);
    wr(a(1, 0), 8'h00);
    @(posedge clk);
    opMode <= 2'h2;
    rd(8'h00, 8'hf8);
    rd(a(1, 0), 8'ha5);
    m.load(3'h0, 16'h1234, 1'b1, 4'h5, 64'h8877665544332211);
    rd(a(0, 1), 8'h34);
    rd(a(0, 2), 8'h45);
    rd(a(0, 11), 8'h44);
    rd(a(0, 3), 8'h04);
    wr(a(0, 1), 8'h00);
    wr(a(0, 11), 8'h00);
    rd(a(0, 1), 8'h34);
    rd(a(0, 11), 8'h44);
    m.load(3'h0, 16'h00ab, 1'b0, 4'h2, 64'h0);
    rd(a(0, 1), 8'h34);
    wr(a(0, 3), 8'h00);
    m.load(3'h0, 16'h00ab, 1'b0, 4'hf, 64'h0);
    rd(a(0, 1), 8'hab);
    rd(a(0, 2), 8'h0f);
    m.load(3'h1, 16'h00cd, 1'b0, 4'h1, 64'h0);
    rd(a(1, 1), 8'h00);
    wr(a(1, 2), 8'hf3);
    rd(a(1, 2), 8'h43);
    wr(a(1, 2), 8'h03);
    wr(a(1, 1), 8'h5a);
    for (int i = 0; i < 8; i++) wr(a(1, 8 + i), 8'h10 + 8'(i));
    rd(a(1, 15), 8'h17);
    snd(1, 8'h03, {3'h1, 16'ha55a, 1'b1, 1'b0, 4'h3}, 3);
    rd(a(1, 3), 8'h02);
    wr(a(1, 2), 8'h48);
    m.slow <= 1'b1;
    snd(1, 8'h01, {3'h1, 16'ha55a, 1'b0, 1'b1, 4'h8}, 0);
    wr(a(1, 2), 8'h08);
    snd(1, 8'h01, {3'h1, 16'ha55a, 1'b0, 1'b0, 4'h8}, 8);
    conclude();
  end
endmodule // cdb_buffers_test

//--- test/cdb_ctrl_model.sv
// Controller stand-in: takes sent frames and offers received ones.
`timescale 1ns/1ps
module cdb_ctrl_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Send side.
  input wire logic txFrameValid,
  input wire logic [24:0] txDesc,
  input wire logic txByteValid,
  input wire logic [7:0] txByteData,
  output logic txByteReady,
  output logic txDone,
  // Receive side.
  output logic rxLoad,
  output logic [2:0] rxBuf,
  output logic [15:0] rxExtId,
  output logic rxRemote,
  output logic [3:0] rxLength,
  output logic [63:0] rxData
);
  logic [7:0] got[$];
  logic [24:0] desc;
  logic slow = 1'b0;
  logic [3:0] ph;
  int nf;
  initial {rxLoad, rxBuf, rxExtId, rxRemote, rxLength, rxData} = '0;
  // A frame ends only once its bytes are drained, so a slow drain delays it.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {txByteReady, txDone, ph} <= '0;
      nf <= 0;
    end else begin
      ph <= ph + 4'h1;
      txByteReady <= !slow || ph[0];
      txDone <= txFrameValid && !txDone && !txByteValid && ph[1:0] == 2'h3;
      if (txByteValid && txByteReady) got.push_back(txByteData);
      if (txDone) desc <= txDesc;
      nf <= nf + int'(txDone);
    end
  end
  task automatic load(input logic [2:0] b, input logic [15:0] id, input logic rem,
      input logic [3:0] len, input logic [63:0] d);
    @(posedge clk);
    {rxLoad, rxBuf, rxExtId, rxRemote, rxLength, rxData} <= {1'b1, b, id, rem, len, d};
    @(posedge clk);
    {rxLoad, rxExtId, rxData} <= {1'b0, ~id, ~d};
  endtask
endmodule // cdb_ctrl_model
